// *** pkg/epvs_regs.svh ***
// Purpose: Constants for the exception priority and vector select block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Ranks are priority plus two, so the fixed -2 maps to rank 0
//
// Function
// - Interrupt line n is vector n+16, table word
// - Configurable priorities reset to zero
// - Table word 0 is stack, then handlers
// - Table base is zero after reset
// - Relocation accepted only 0x100 to 0x3FFFFF00
// - Only privileged writes may relocate the base
// - Smaller priority value is more urgent
// - All priorities configurable except reset, hard fault, nonmaskable
// - Configurable priority fields hold 0 to 7
// - Equal priority ties go to lowest number
// - Strictly more urgent arrival preempts active handler
// - Equal priority never preempts; stays pending instead
// - Asserted interrupt that cannot preempt becomes pending
// - Nonmaskable request always enabled, fixed priority -2
// - Hard fault has fixed priority -1
`ifndef EPVS_REGS_SVH
`define EPVS_REGS_SVH

// Register byte offsets
`define EPVS_OFS_VBASE 12'h000
`define EPVS_OFS_IRQEN0 12'h004
`define EPVS_OFS_IRQEN1 12'h008
`define EPVS_OFS_SYSEN 12'h00C
`define EPVS_OFS_SWPEND 12'h010
`define EPVS_OFS_STAT 12'h014
`define EPVS_OFS_PRIO0 12'h020
`define EPVS_OFS_PRIO7 12'h03C

// Sizes
`define EPVS_NVEC 60
`define EPVS_NIRQ 44
`define EPVS_IRQ_VEC0 16

// Vector numbers of the system exceptions
`define EPVS_VEC_NMI 2
`define EPVS_VEC_HARD 3
`define EPVS_VEC_MEM 4
`define EPVS_VEC_USAGE 6
`define EPVS_VEC_SVC 11
`define EPVS_VEC_DBG 12
`define EPVS_VEC_PENDED_SERVICE_REQUEST 14
`define EPVS_VEC_SYSTICK 15

// Lines that really have a source attached
`define EPVS_IRQ_PRESENT 44'h400F7FFC7FF

// Relocation window on base bits 31:8
`define EPVS_VBASE_MIN 24'h000001
`define EPVS_VBASE_MAX 24'h3FFFFF
`define EPVS_VBASE_RST 24'h000000

// Priority and rank encodings
`define EPVS_PRIO_RST 3'h0
`define EPVS_RANK_NMI 4'h0
`define EPVS_RANK_HARD 4'h1
`define EPVS_RANK_OFS 4'h2
`define EPVS_RANK_NONE 4'hF

`endif

// *** pkg/epvs_pkg.sv ***
// Purpose: Shared types of the exception priority and vector select block
// Assumes: Sixty vector slots
// Notes: Constants live in epvs_regs.svh
package epvs_pkg;
  typedef logic [5:0] epvs_vec_t; // Vector number
  typedef logic [3:0] epvs_rank_t; // Urgency rank, 0 most urgent
  typedef logic [2:0] epvs_prio_t; // Configurable priority field
endpackage : epvs_pkg

// *** core/epvs_prio_sel.sv ***
// Purpose: Pick the most urgent requesting vector
// Assumes: Ranks packed four bits per vector, vector 0 lowest
// Notes: Pure combinational, one linear scan
`include "epvs_regs.svh"

module epvs_prio_sel (
  // Requests and their ranks
  input wire logic [`EPVS_NVEC-1:0] req,
  input wire logic [`EPVS_NVEC*4-1:0] rank_flat,
  // Winner
  output logic valid,
  output epvs_pkg::epvs_vec_t vec,
  output epvs_pkg::epvs_rank_t rank
);

  // Linear scan; strict compare keeps the earliest index on a tie
  always_comb
  begin
    valid = 1'b0;
    vec = 6'h00;
    rank = `EPVS_RANK_NONE;
    for (int i = 0; i < `EPVS_NVEC; i++)
    begin
      // Smaller rank wins, equal rank keeps lower number
      if (req[i] && (!valid || rank_flat[i*4 +: 4] < rank))
      begin
        valid = 1'b1;
        vec = 6'(i);
        rank = rank_flat[i*4 +: 4];
      end
    end
  end

endmodule : epvs_prio_sel

// *** core/epvs_top.sv ***
// Purpose: Exception priority resolution and vector address generation
// Assumes: Core handshakes on pclk; interrupt and NMI pins are asynchronous
// Notes: APB slave answers with one wait state; all outputs are registered
//
// Local design decisions: the placing of the registers and the APB slave port.
`include "epvs_regs.svh"

module epvs_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous request pins
  input wire logic [`EPVS_NIRQ-1:0] peripheral_interrupt_line,
  input wire logic nmi_pin,
  // Synchronous exception sources from the core
  input wire logic hard_fault_req,
  input wire logic mem_fault_req,
  input wire logic bus_fault_req,
  input wire logic usage_fault_req,
  input wire logic supervisor_call_exception,
  input wire logic debug_mon_req,
  input wire logic systick_req,
  // Core entry and return handshake
  input wire logic core_take,
  input wire logic core_ret,
  input wire epvs_pkg::epvs_vec_t core_ret_vec,
  // Selection presented to the core
  output logic exc_req,
  output epvs_pkg::epvs_vec_t exc_vec,
  output logic [3:0] exc_pri,
  output logic [31:0] handler_addr,
  output logic [31:0] stack_init_addr
);

  // One-hot decode, used for entry and for return
  function automatic logic [`EPVS_NVEC-1:0] vec_onehot(input epvs_pkg::epvs_vec_t v);
    logic [`EPVS_NVEC-1:0] oh;
    oh = '0;
    oh[v] = 1'b1;
    return oh;
  endfunction : vec_onehot

  // True where software may set the priority
  function automatic logic is_cfg(input int v);
    return (v >= `EPVS_VEC_MEM && v <= `EPVS_VEC_USAGE) ||
           v == `EPVS_VEC_SVC || v == `EPVS_VEC_DBG ||
           v >= `EPVS_VEC_PENDED_SERVICE_REQUEST;
  endfunction : is_cfg

  // Urgency rank of one vector
  function automatic epvs_pkg::epvs_rank_t rank_of(input int v, input epvs_pkg::epvs_prio_t p);
    if (v == `EPVS_VEC_NMI)
      return `EPVS_RANK_NMI;
    else if (v == `EPVS_VEC_HARD)
      return `EPVS_RANK_HARD;
    else
      return {1'b0, p} + `EPVS_RANK_OFS;
  endfunction : rank_of

  // Register state
  logic [23:0] vbase_q; // Table base bits 31:8
  logic [31:0] irq_en0_q; // Enables for lines 0..31
  logic [11:0] irq_en1_q; // Enables for lines 32..43
  logic [3:0] sys_en_q; // Mem, bus, usage, debug monitor enables
  epvs_pkg::epvs_prio_t prio_q [`EPVS_NVEC]; // Priority per vector
  logic [`EPVS_NVEC-1:0] pend_q; // Pending flags
  logic [`EPVS_NVEC-1:0] active_q; // Active flags, nesting allowed

  // Synchronisers and edge history
  logic [`EPVS_NIRQ-1:0] irq_meta_q;
  logic [`EPVS_NIRQ-1:0] irq_sync_q;
  logic [`EPVS_NIRQ-1:0] irq_prev_q;
  logic nmi_meta_q;
  logic nmi_sync_q;
  logic nmi_prev_q;

  // APB output registers
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Core-facing output registers
  logic exc_req_q;
  epvs_pkg::epvs_vec_t exc_vec_q;
  logic [3:0] exc_pri_q;
  logic [31:0] handler_addr_q;
  logic [31:0] stack_init_addr_q;

  // Bus decode
  wire acc = psel & penable; // Access phase
  wire wr_fire = acc & pready_q & pwrite; // Commit edge
  wire in_page = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00);
  wire sel_vbase = paddr == `EPVS_OFS_VBASE;
  wire sel_en0 = paddr == `EPVS_OFS_IRQEN0;
  wire sel_en1 = paddr == `EPVS_OFS_IRQEN1;
  wire sel_sysen = paddr == `EPVS_OFS_SYSEN;
  wire sel_swpend = paddr == `EPVS_OFS_SWPEND;
  wire sel_stat = paddr == `EPVS_OFS_STAT;
  wire sel_prio = in_page && paddr >= `EPVS_OFS_PRIO0 && paddr <= `EPVS_OFS_PRIO7;
  wire mapped = sel_vbase | sel_en0 | sel_en1 | sel_sysen | sel_swpend |
                sel_stat | sel_prio;
  wire [2:0] prio_word = paddr[4:2]; // Which group of eight vectors

  // Relocation accepted only inside the window and only when privileged
  wire vbase_ok = pwdata[31:8] >= `EPVS_VBASE_MIN &&
                  pwdata[31:8] <= `EPVS_VBASE_MAX;
  wire vbase_wr = wr_fire & sel_vbase & pprot[0] & vbase_ok;

  // Software pend requests
  wire sw_pended_service_request = wr_fire & sel_swpend & pwdata[0];
  wire sw_systick = wr_fire & sel_swpend & pwdata[1];

  // Rising edges of real lines only; dead lines never pend
  wire [`EPVS_NIRQ-1:0] irq_rise = irq_sync_q & ~irq_prev_q &
                                   `EPVS_IRQ_PRESENT;
  wire nmi_rise = nmi_sync_q & ~nmi_prev_q;

  // New events placed at their vector numbers
  wire [15:0] sys_set = {systick_req | sw_systick, sw_pended_service_request, 1'b0,
                         debug_mon_req, supervisor_call_exception, 4'h0,
                         usage_fault_req, bus_fault_req, mem_fault_req,
                         hard_fault_req, nmi_rise, 2'b00};
  wire [`EPVS_NVEC-1:0] set_v = {irq_rise, sys_set};

  // Enables; NMI and hard fault cannot be turned off
  wire [15:0] sys_en = {2'b11, 1'b0, sys_en_q[3], 1'b1, 4'h0,
                        sys_en_q[2:0], 2'b11, 2'b00};
  wire [`EPVS_NVEC-1:0] en_v = {irq_en1_q, irq_en0_q, sys_en} &
                               {`EPVS_IRQ_PRESENT, 16'hFFFF};

  // Winner of the pending set and rank of the running handler
  logic [`EPVS_NVEC*4-1:0] rank_flat;
  logic win_valid;
  epvs_pkg::epvs_vec_t win_vec;
  epvs_pkg::epvs_rank_t win_rank;
  logic act_valid;
  epvs_pkg::epvs_vec_t act_vec;
  epvs_pkg::epvs_rank_t act_rank;

  // Entry and return decode
  wire take_ok = core_take & exc_req_q;
  wire [`EPVS_NVEC-1:0] take_oh = take_ok ? vec_onehot(exc_vec_q) : '0;
  wire [`EPVS_NVEC-1:0] ret_oh = core_ret ? vec_onehot(core_ret_vec) : '0;

  // Entry only when strictly more urgent than every active handler
  wire preempt = win_valid &&
                 (!act_valid || win_rank < act_rank);

  // Fetch address and stack word address
  wire [31:0] base_addr = {vbase_q, 8'h00};
  wire [31:0] fetch_addr = base_addr +
                           {24'h000000, win_vec, 2'b00};

  // Priority readback, four bits per slot, unused slots zero
  logic [255:0] prio_all;

  // Per-vector rank, priority storage and readback slot
  for (genvar v = 0; v < 64; v++)
  begin : g_vec
    if (v < `EPVS_NVEC)
    begin : g_real
      assign rank_flat[v*4 +: 4] = rank_of(v, prio_q[v]);
      assign prio_all[v*4 +: 4] = {1'b0, prio_q[v]};
      // Field update; fixed vectors ignore writes
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          prio_q[v] <= `EPVS_PRIO_RST;
        else if (wr_fire && sel_prio && prio_word == 3'(v / 8) && is_cfg(v))
          prio_q[v] <= pwdata[(v % 8) * 4 +: 3];
      end
    end
    else
    begin : g_pad
      assign prio_all[v*4 +: 4] = 4'h0;
    end
  end

  // Read mux
  wire [31:0] stat_word = {7'h00, act_valid, 2'h0, act_vec, 3'h0,
                           win_valid, win_rank, 2'h0, win_vec};
  wire [31:0] rd_mux = sel_vbase ? base_addr :
                       sel_en0 ? irq_en0_q :
                       sel_en1 ? {20'h00000, irq_en1_q} :
                       sel_sysen ? {28'h0000000, sys_en_q} :
                       sel_swpend ? {30'h00000000, pend_q[`EPVS_VEC_SYSTICK],
                                     pend_q[`EPVS_VEC_PENDED_SERVICE_REQUEST]} :
                       sel_stat ? stat_word :
                       sel_prio ? prio_all[prio_word*32 +: 32] : 32'h00000000;

  // Pending set beats the entry clear in the same cycle
  wire [`EPVS_NVEC-1:0] pend_d = (pend_q & ~take_oh) | set_v;
  wire [`EPVS_NVEC-1:0] active_d = (active_q & ~ret_oh) | take_oh;

  // Most urgent pending and enabled request
  epvs_prio_sel u_pend_sel (
    .req(pend_q & en_v),
    .rank_flat(rank_flat),
    .valid(win_valid),
    .vec(win_vec),
    .rank(win_rank)
  );

  // Most urgent active handler, the preemption threshold
  epvs_prio_sel u_act_sel (
    .req(active_q),
    .rank_flat(rank_flat),
    .valid(act_valid),
    .vec(act_vec),
    .rank(act_rank)
  );

  // Two-flop synchronisers; only the second stage feeds logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_meta_q <= '0;
      irq_sync_q <= '0;
      irq_prev_q <= '0;
      nmi_meta_q <= 1'b0;
      nmi_sync_q <= 1'b0;
      nmi_prev_q <= 1'b0;
    end
    else
    begin
      irq_meta_q <= peripheral_interrupt_line;
      irq_sync_q <= irq_meta_q;
      irq_prev_q <= irq_sync_q;
      nmi_meta_q <= nmi_pin;
      nmi_sync_q <= nmi_meta_q;
      nmi_prev_q <= nmi_sync_q;
    end
  end

  // Pending and active bookkeeping
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q <= '0;
      active_q <= '0;
    end
    else
    begin
      pend_q <= pend_d;
      active_q <= active_d;
    end
  end

  // Table base; reset forgets any earlier relocation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vbase_q <= `EPVS_VBASE_RST;
    else if (vbase_wr)
      vbase_q <= pwdata[31:8];
  end

  // Enable registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_en0_q <= 32'h00000000;
      irq_en1_q <= 12'h000;
      sys_en_q <= 4'h0;
    end
    else
    begin
      // Each write touches one register only
      if (wr_fire && sel_en0)
        irq_en0_q <= pwdata;
      if (wr_fire && sel_en1)
        irq_en1_q <= pwdata[11:0];
      if (wr_fire && sel_sysen)
        sys_en_q <= pwdata[3:0];
    end
  end

  // APB answer; one wait state keeps every bus output registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= acc & ~pready_q;
      // Data captured at the wait cycle, held through the ready cycle
      if (acc && !pready_q)
      begin
        prdata_q <= (mapped && !pwrite) ? rd_mux : 32'h00000000;
        pslverr_q <= ~mapped;
      end
      else if (!acc)
      begin
        prdata_q <= 32'h00000000;
        pslverr_q <= 1'b0;
      end
    end
  end

  // Core-facing selection, refreshed every cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exc_req_q <= 1'b0;
      exc_vec_q <= 6'h00;
      exc_pri_q <= 4'h0;
      handler_addr_q <= 32'h00000000;
      stack_init_addr_q <= 32'h00000000;
    end
    else
    begin
      // Drop for a cycle after entry so a stale winner is never offered
      exc_req_q <= preempt & ~take_ok;
      exc_vec_q <= win_vec;
      exc_pri_q <= win_rank - `EPVS_RANK_OFS;
      handler_addr_q <= fetch_addr;
      stack_init_addr_q <= base_addr;
    end
  end

  // Port drive, all from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign exc_req = exc_req_q;
  assign exc_vec = exc_vec_q;
  assign exc_pri = exc_pri_q;
  assign handler_addr = handler_addr_q;
  assign stack_init_addr = stack_init_addr_q;

endmodule : epvs_top

// *** dv/epvs_checker.sv ***
// Purpose: Port checks of the exception select block
// Assumes: One pclk domain, presetn async active low
// Notes: Bound onto epvs_top below the module
module epvs_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Sources and core handshake
  input wire logic nmi_pin,
  input wire logic core_take,
  // Selection
  input wire logic exc_req,
  input wire epvs_pkg::epvs_vec_t exc_vec,
  input wire logic [3:0] exc_pri,
  input wire logic [31:0] handler_addr,
  input wire logic [31:0] stack_init_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Access phase opens
  sequence s_acc;
    psel && $rose(penable);
  endsequence
  // Exactly one wait state, then ready
  sequence s_wait1;
    !pready ##1 pready;
  endsequence
  // Nonmaskable offered at its own vector
  sequence s_nmi_offer;
    exc_req && exc_vec == 6'h02;
  endsequence
  AST_APB_WAIT: assert property (s_acc |-> s_wait1)
    else $error("pready not after one wait");
  AST_FETCH: assert property (
    handler_addr == stack_init_addr + {24'h0, exc_vec, 2'h0})
    else $error("bad fetch address");
  AST_ALIGN: assert property (stack_init_addr[7:0] == 8'h00)
    else $error("base not aligned");
  AST_RANGE: assert property (
    stack_init_addr inside {32'h0, [32'h100:32'h3FFF_FF00]})
    else $error("base out of range");
  AST_RST_BASE: assert property ($rose(presetn) |-> stack_init_addr == 32'h0)
    else $error("base not zero after reset");
  AST_PRI: assert property (
    exc_req |-> exc_pri inside {[4'h0:4'h7], 4'hE, 4'hF})
    else $error("priority out of range");
  AST_NMI_PRI: assert property (
    exc_req && exc_vec == 6'h02 |-> exc_pri == 4'hE)
    else $error("nonmaskable priority wrong");
  AST_HARD_PRI: assert property (
    exc_req && exc_vec == 6'h03 |-> exc_pri == 4'hF)
    else $error("hard fault priority wrong");
  AST_RSVD: assert property (
    exc_req |-> !(exc_vec inside {[0:1], [7:10], 13, [27:29], [48:57], 59}))
    else $error("unconnected vector offered");
  AST_TAKE: assert property (exc_req && core_take |=> !exc_req)
    else $error("offer held after take");
  AST_NMI: assert property ($rose(nmi_pin) |-> ##[2:8] s_nmi_offer)
    else $error("nonmaskable not offered");
endmodule : epvs_checker

bind epvs_top epvs_checker u_chk (
  .pclk, .presetn, .psel, .penable, .pready, .nmi_pin, .core_take,
  .exc_req, .exc_vec, .exc_pri, .handler_addr, .stack_init_addr
);

// *** dv/epvs_core_model.sv ***
// Purpose: Core entry model that takes offers and returns
// Assumes: Takes after lat cycles of offer, returns two later
// Notes: Records vector and fetched entry of each take
module epvs_core_model (
  // Clock and bench control
  input wire logic pclk,
  input wire logic take_en,
  input wire logic ret_en,
  input wire logic [3:0] lat,
  // Offer from the block
  input wire logic exc_req,
  input wire epvs_pkg::epvs_vec_t exc_vec,
  input wire logic [31:0] handler_addr,
  // Handshake back
  output logic core_take,
  output logic core_ret,
  output epvs_pkg::epvs_vec_t core_ret_vec,
  // Record of last entry
  output epvs_pkg::epvs_vec_t got_vec,
  output logic [31:0] got_entry,
  output int got_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0; // Cycles the offer has stood
  logic ret_q = 1'h0; // Return due next cycle
  initial
  begin
    {core_take, core_ret, core_ret_vec, got_vec, got_entry} = '0;
    got_n = 0;
  end
  // Take only a standing offer; wait restarts whenever it drops
  always @(posedge pclk)
  begin
    core_take <= 1'h0;
    core_ret <= ret_q;
    ret_q <= 1'h0;
    if (core_take && exc_req)
    begin
      got_vec <= exc_vec;
      got_entry <= handler_addr | 32'h1;
      got_n <= got_n + 1;
      core_ret_vec <= exc_vec;
      ret_q <= ret_en;
    end
    if (!take_en || !exc_req || core_take)
      cnt <= 4'h0;
    else if (cnt == lat)
      core_take <= 1'h1;
    else
      cnt <= cnt + 4'h1;
  end
endmodule : epvs_core_model

// *** dv/exception_priority_vector_select_tb.sv ***
// Purpose: Self-checking bench of the exception select block
// Assumes: APB slave with one wait state, core model takes offers
// Notes: A cycle ceiling cuts hangs short
module exception_priority_vector_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench driven inputs
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic nmi_pin = 1'h0, take_en = 1'h0, ret_en = 1'h1, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, handler_addr, stack_init_addr, got_entry, rd, vb;
  logic [2:0] pprot = '0;
  logic [43:0] irq = '0;
  logic [6:0] sysr = '0; // Hard, mem, bus, usage, svc, debug, systick
  logic [3:0] lat = '0, exc_pri;
  logic pready, pslverr, core_take, core_ret, exc_req;
  epvs_pkg::epvs_vec_t exc_vec, core_ret_vec, got_vec;
  int got_n, seen = 0, bad_count = 0, compares = 0, cyc = 0;
  logic [5:0] sv [7] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h0B, 6'h0C, 6'h0F}; // Source vectors
  epvs_top dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot, .prdata,
    .pready, .pslverr, .peripheral_interrupt_line(irq), .nmi_pin,
    .hard_fault_req(sysr[0]), .mem_fault_req(sysr[1]), .bus_fault_req(sysr[2]),
    .usage_fault_req(sysr[3]), .supervisor_call_exception(sysr[4]),
    .debug_mon_req(sysr[5]), .systick_req(sysr[6]), .core_take, .core_ret,
    .core_ret_vec, .exc_req, .exc_vec, .exc_pri, .handler_addr, .stack_init_addr
  );
  epvs_core_model u_core (
    .pclk, .take_en, .ret_en, .lat, .exc_req, .exc_vec, .handler_addr, .core_take,
    .core_ret, .core_ret_vec, .got_vec, .got_entry, .got_n
  );
  // 8 ns clock
  always #4 pclk = ~pclk;
  // Cycle ceiling
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      $display("FAIL %0t timeout", $time);
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Winner as seen by the core
  function automatic logic [31:0] sel();
    return {21'h0, exc_req, exc_vec, exc_pri};
  endfunction : sel
  // One transfer held until pready, then an idle cycle so strobes never double up
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [2:0] pr);
    {psel, penable, pwrite, paddr, pwdata, pprot} <= {2'h2, w, a, d, pr};
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1); // Only the cycle ceiling ends a hung wait
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask : apb
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [2:0] pr,
                       input logic [31:0] exp);
    apb(1'h1, a, d, pr);
    apb(1'h0, a, 32'h0, 3'h1);
    chk(rd, exp);
  endtask : wr_rd
  // Await one core entry; vector 0 means none may come
  task automatic expect_take(input logic [5:0] v);
    int k = 0;
    while (got_n == seen && k++ < 40)
      @(posedge pclk);
    if (v == 6'h0)
      chk(got_n, seen);
    else
    begin
      chk(got_n, seen + 1);
      chk({26'h0, got_vec}, {26'h0, v});
      chk(got_entry, vb + {24'h0, v, 2'h0} + 32'h1);
    end
    seen = got_n;
  endtask : expect_take
  task automatic do_reset();
    {presetn, take_en, ret_en, lat} <= {3'h1, 4'h0};
    vb = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
  endtask : do_reset
  task automatic t_reset();
    chk(stack_init_addr, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      apb(1'h0, 12'h020 + 12'(4 * k), 32'h0, 3'h1);
      chk(rd, 32'h0);
    end
    apb(1'h0, 12'h018, 32'h0, 3'h1);
    chk({31'h0, err}, 32'h1);
  endtask : t_reset
  task automatic t_vbase();
    wr_rd(12'h000, 32'h0000_2000, 3'h0, 32'h0);
    wr_rd(12'h000, 32'h0000_00FF, 3'h1, 32'h0);
    wr_rd(12'h000, 32'h4000_0000, 3'h1, 32'h0);
    wr_rd(12'h000, 32'h3FFF_FF00, 3'h1, 32'h3FFF_FF00);
    wr_rd(12'h000, 32'h0001_2300, 3'h1, 32'h0001_2300);
    chk(stack_init_addr, 32'h0001_2300);
    do_reset();
    chk(stack_init_addr, 32'h0);
  endtask : t_vbase
  // Every system source but the nonmaskable pin, prompt core
  task automatic t_sys();
    vb = 32'h0000_0100;
    wr_rd(12'h000, vb, 3'h1, vb);
    apb(1'h1, 12'h00C, 32'hF, 3'h1);
    take_en <= 1'h1;
    for (int i = 0; i < 7; i++)
    begin
      sysr[i] <= 1'h1;
      @(posedge pclk);
      sysr[i] <= 1'h0;
      expect_take(sv[i]);
    end
    apb(1'h1, 12'h010, 32'h1, 3'h1);
    expect_take(6'h0E);
    // Software pend of the timer tick
    apb(1'h1, 12'h010, 32'h2, 3'h1);
    expect_take(6'h0F);
    chk(stack_init_addr, vb);
  endtask : t_sys
  // Every line, slow core
  task automatic t_irq();
    apb(1'h1, 12'h004, 32'hFFFF_FFFF, 3'h1);
    apb(1'h1, 12'h008, 32'h0000_0FFF, 3'h1);
    lat <= 4'h5;
    for (int n = 0; n < 44; n++)
    begin
      irq[n] <= 1'h1;
      @(posedge pclk);
      irq[n] <= 1'h0;
      if (n inside {[11:13], 27, [32:41], 43})
        expect_take(6'h0);
      else
        expect_take(6'(n + 16));
    end
  endtask : t_irq
  task automatic t_prio();
    apb(1'h1, 12'h004, 32'hFFFF_FFFF, 3'h1);
    wr_rd(12'h020, 32'hFFFF_FFFF, 3'h1, 32'h0777_0000);
    wr_rd(12'h028, 32'h0000_0013, 3'h1, 32'h0000_0013);
    irq[1:0] <= 2'h3;
    @(posedge pclk);
    irq[1:0] <= 2'h0;
    repeat (6) @(posedge pclk);
    chk(sel(), {1'h1, 6'h11, 4'h1});
    wr_rd(12'h028, 32'h0000_0122, 3'h1, 32'h0000_0122);
    chk(sel(), {1'h1, 6'h10, 4'h2});
    {ret_en, take_en} <= 2'h1;
    expect_take(6'h10);
    take_en <= 1'h0;
    repeat (4) @(posedge pclk);
    chk({31'h0, exc_req}, 32'h0);
    apb(1'h0, 12'h014, 32'h0, 3'h1);
    chk(rd & 32'h0000_103F, 32'h0000_1011);
    irq[2] <= 1'h1;
    @(posedge pclk);
    irq[2] <= 1'h0;
    repeat (6) @(posedge pclk);
    chk(sel(), {1'h1, 6'h12, 4'h1});
    {nmi_pin, sysr[0]} <= 2'h3;
    @(posedge pclk);
    sysr[0] <= 1'h0;
    repeat (6) @(posedge pclk);
    chk(sel(), {1'h1, 6'h02, 4'hE});
    {ret_en, take_en} <= 2'h3;
    expect_take(6'h02);
    expect_take(6'h03);
    expect_take(6'h12);
    nmi_pin <= 1'h0;
  endtask : t_prio
  initial
  begin
    do_reset();
    t_reset();
    t_vbase();
    t_sys();
    t_irq();
    do_reset();
    t_prio();
    summarize();
  end
endmodule : exception_priority_vector_select_tb
